/* core/pmw_top.sv */
// Power mode controller and watchdog with a classic Wishbone register port.
// What this block does
// - Idle bit write enters idle after it
// - Idle stops only processor clock, freezes state
// - Enabled interrupt in idle clears bit, wakes
// - Any reset also ends idle mode
// - Reset loads vector 0000h, resets special registers
// - Power-down bit write stops all clocks
// - Pins keep register values in power-down
// - Reset pin high ends power-down, restarts
// - Watchdog cannot end power-down
// - Enabled level external interrupt ends power-down
// - After wake, execution resumes past entry
// - Watchdog divider chain resets system on time-out
// - Any reset disables and clears watchdog
// - Watchdog runs only while enabled
// - Clear bit resets timer, prescaler, self-clears
// - Idle-run bit keeps watchdog alive in idle
// - Prescale factor is two to code plus one
// - Time-out is 2^14 times factor times 12
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "pmw_cfg.svh"
module pmw_top
    import pmw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rst_pin,
    input wire logic ext_int_pin,
    input wire logic irq_req,
    input wire logic ext_int_en,
    input wire logic global_interrupt_enable,
    input wire logic ext_int_level_mode,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic port_hold,
    output logic sfr_reset,
    output logic wake_pulse,
    output logic [15:0] reset_vector
);
    pmw_wd_if wdi ();

    ////////////////////////////////////////////////////////////////////////////
    // Reset sources.

    logic pin_rst;
    logic sys_rst_q;
    logic eint1_q;
    logic eint2_q;

    pmw_rst_filt u_filt (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .rst_pin(rst_pin),
        .rst_valid(pin_rst)
    );

    pmw_wdog u_wdog (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .wd(wdi)
    );

    // The interrupt pin is asynchronous, so it passes two flops first.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            eint1_q <= 1'b0;
            eint2_q <= 1'b0;
        end else begin
            eint1_q <= ext_int_pin;
            eint2_q <= eint1_q;
        end
    end

    // System reset is the filtered pin or an enabled watchdog time-out.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sys_rst_q <= 1'b1;
        end else begin
            sys_rst_q <= pin_rst || (wdi.timeout && wdi.rst_en);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave; one wait state, every access answered, unmapped reads zero.

    logic ack_q;
    logic [31:0] dat_q;
    logic bus_req;
    logic wr_lane0;

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    ////////////////////////////////////////////////////////////////////////////
    // Mode controller.

    pmw_mode_t mode_q;
    logic wr_pctl;
    logic pd_wake;
    logic idle_wake;

    assign wr_pctl = wr_lane0 && (wb_adr_i == `PMW_ADR_PCTL);
    // Only a level-mode, enabled external interrupt restarts the stopped oscillator.
    assign pd_wake = eint2_q && ext_int_en && global_interrupt_enable
                     && ext_int_level_mode;
    assign idle_wake = irq_req;

    // Entry takes effect after the writing access; power-down wins over idle.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= PMW_RUN;
        end else if (sys_rst_q) begin
            mode_q <= PMW_RUN;
        end else begin
            unique case (mode_q)
                PMW_RUN: begin
                    if (wr_pctl && wb_dat_i[`PMW_PCTL_PD_BIT]) begin
                        mode_q <= PMW_PDOWN;
                    end else if (wr_pctl && wb_dat_i[`PMW_PCTL_IDLE_BIT]) begin
                        mode_q <= PMW_IDLE;
                    end
                end
                PMW_IDLE: begin
                    if (idle_wake) begin
                        mode_q <= PMW_RUN;
                    end
                end
                PMW_PDOWN: begin
                    if (pd_wake) begin
                        mode_q <= PMW_RUN;
                    end
                end
                default: begin
                    mode_q <= PMW_RUN;
                end
            endcase
        end
    end

    // Wake pulse tells the core to take the interrupt and then carry on past the entry.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= !sys_rst_q && ((mode_q == PMW_IDLE && idle_wake)
                          || (mode_q == PMW_PDOWN && pd_wake));
        end
    end

    // Clock gates and freeze follow the mode; outputs come from flops.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b1;
            port_hold <= 1'b0;
        end else begin
            cpu_clk_en <= (mode_q == PMW_RUN) && !(wr_pctl && (wb_dat_i[1:0] != 2'b00));
            periph_clk_en <= !(mode_q == PMW_PDOWN || (mode_q == PMW_RUN && wr_pctl
                             && wb_dat_i[`PMW_PCTL_PD_BIT]));
            port_hold <= (mode_q != PMW_RUN) || (wr_pctl && (wb_dat_i[1:0] != 2'b00));
        end
    end

    // Reset vector and special-register reset are presented to the core.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sfr_reset <= 1'b1;
            reset_vector <= `PMW_RESET_VECTOR;
        end else begin
            sfr_reset <= sys_rst_q;
            reset_vector <= `PMW_RESET_VECTOR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog control register.

    logic [7:0] wdc_q;
    logic wr_wdc;

    assign wr_wdc = wr_lane0 && (wb_adr_i == `PMW_ADR_WDC);

    // Any reset returns the watchdog to disabled; clear bit drops once served.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wdc_q <= `PMW_WDC_RESET;
        end else if (sys_rst_q) begin
            wdc_q <= `PMW_WDC_RESET;
        end else if (wr_wdc) begin
            wdc_q <= wb_dat_i[7:0];
            wdc_q[3] <= 1'b0;
        end else if (wdi.clr_done) begin
            wdc_q[`PMW_WDC_CLR_BIT] <= 1'b0;
        end
    end

    assign wdi.srst = sys_rst_q;
    assign wdi.run_en = wdc_q[`PMW_WDC_RUN_BIT];
    assign wdi.clr = wdc_q[`PMW_WDC_CLR_BIT];
    assign wdi.idle_run = wdc_q[`PMW_WDC_IDLE_RUN_BIT];
    assign wdi.rst_en = wdc_q[`PMW_WDC_RSTEN_BIT];
    assign wdi.psel = wdc_q[`PMW_WDC_PS_MSB:`PMW_WDC_PS_LSB];
    assign wdi.in_idle = (mode_q == PMW_IDLE);
    assign wdi.halt = (mode_q == PMW_PDOWN);

    ////////////////////////////////////////////////////////////////////////////
    // Reset cause flags; they survive the system reset and are write-one-to-clear.

    logic wdrst_q;
    logic pinrst_q;
    logic wr_stat;

    assign wr_stat = wr_lane0 && (wb_adr_i == `PMW_ADR_STAT);

    // A new event in the clearing cycle wins over the clear.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wdrst_q <= 1'b0;
            pinrst_q <= 1'b0;
        end else begin
            if (wdi.timeout && wdi.rst_en) begin
                wdrst_q <= 1'b1;
            end else if (wr_stat && wb_dat_i[`PMW_STAT_WDRST_BIT]) begin
                wdrst_q <= 1'b0;
            end
            if (pin_rst) begin
                pinrst_q <= 1'b1;
            end else if (wr_stat && wb_dat_i[`PMW_STAT_PINRST_BIT]) begin
                pinrst_q <= 1'b0;
            end
        end
    end

    // Read data is latched together with the acknowledge.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dat_q <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                `PMW_ADR_PCTL: dat_q <= {30'h0000_0000, mode_q == PMW_PDOWN,
                                         mode_q == PMW_IDLE};
                `PMW_ADR_WDC: dat_q <= {24'h00_0000, wdc_q};
                `PMW_ADR_STAT: dat_q <= {28'h000_0000, pinrst_q, wdrst_q,
                                         mode_q == PMW_PDOWN, mode_q == PMW_IDLE};
                default: dat_q <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_pd_request;
        mode_q == PMW_RUN && !sys_rst_q && wr_pctl && wb_dat_i[1:0] == 2'b11;
    endsequence

    sequence s_pd_entered;
        mode_q == PMW_PDOWN ##1 !periph_clk_en && !cpu_clk_en;
    endsequence

    a_pd_priority: assert property (s_pd_request |=> s_pd_entered)
        else $error("both mode bits did not give power-down");
    a_idle_entry: assert property (
        (mode_q == PMW_RUN && !sys_rst_q && wr_pctl && wb_dat_i[1:0] == 2'b01)
        |=> mode_q == PMW_IDLE && !cpu_clk_en && periph_clk_en)
        else $error("idle write did not stop only the processor clock");
    a_idle_wake: assert property (
        (mode_q == PMW_IDLE && irq_req && !sys_rst_q) |=> mode_q == PMW_RUN && wake_pulse
        ##1 cpu_clk_en)
        else $error("interrupt did not end idle");
    a_reset_ends: assert property (
        sys_rst_q |=> mode_q == PMW_RUN && wdc_q == `PMW_WDC_RESET && sfr_reset)
        else $error("reset did not end low-power mode or disable watchdog");
    a_pd_hold: assert property (
        mode_q == PMW_PDOWN |=> port_hold && !periph_clk_en)
        else $error("pins released or clocks running in power-down");
    a_pd_no_wake: assert property (
        (mode_q == PMW_PDOWN && !sys_rst_q && !(eint2_q && ext_int_level_mode
         && ext_int_en && global_interrupt_enable)) |=> mode_q == PMW_PDOWN)
        else $error("power-down left without a qualifying wake source");
    a_pd_pin_wake: assert property (
        (mode_q == PMW_PDOWN && pin_rst) |=> ##[1:2] mode_q == PMW_RUN)
        else $error("reset pin did not end power-down");
    a_vector_zero: assert property (reset_vector == 16'h0000)
        else $error("reset vector is not zero");

    // Gating, wake, watchdog, flag and bus handshake checks.
    a_idle_clocks: assert property (
        mode_q == PMW_IDLE |=> !cpu_clk_en && periph_clk_en && port_hold)
        else $error("idle gating wrong");
    a_pd_entry: assert property (
        (mode_q == PMW_RUN && !sys_rst_q && wr_pctl && wb_dat_i[1:0] == 2'b10)
        |=> mode_q == PMW_PDOWN && !cpu_clk_en && !periph_clk_en)
        else $error("power-down write did not stop all clocks");
    a_idle_stays: assert property (
        (mode_q == PMW_IDLE && !idle_wake && !sys_rst_q) |=> mode_q == PMW_IDLE)
        else $error("idle left without interrupt or reset");
    a_wake_single: assert property (
        wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    a_pd_wake: assert property (
        (mode_q == PMW_PDOWN && !sys_rst_q && pd_wake) |=> mode_q == PMW_RUN && wake_pulse)
        else $error("qualified interrupt did not end power-down");
    a_wd_reset: assert property (
        (wdi.timeout && wdi.rst_en) |=> sys_rst_q && wdrst_q)
        else $error("enabled time-out gave no system reset");
    a_wd_off: assert property (
        sys_rst_q |=> !wdi.run_en && !wdi.clr)
        else $error("reset left the watchdog running");
    a_clr_self: assert property (
        (wdi.clr_done && !wr_wdc) |=> !wdi.clr)
        else $error("clear bit did not drop once served");
    a_pin_flag: assert property (
        pin_rst |=> pinrst_q)
        else $error("pin reset not recorded");
    a_sfr_release: assert property (
        $fell(sys_rst_q) |=> !sfr_reset)
        else $error("special-register reset stuck after reset");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge stood two cycles");
endmodule : pmw_top

/* common/pmw_cfg.svh */
// Offsets, bit positions, reset values and timing counts of the power mode and watchdog block.
`ifndef PMW_CFG_SVH
`define PMW_CFG_SVH
`define PMW_ADR_PCTL 8'h00
`define PMW_ADR_WDC 8'h04
`define PMW_ADR_STAT 8'h08
`define PMW_PCTL_IDLE_BIT 0
`define PMW_PCTL_PD_BIT 1
`define PMW_WDC_RUN_BIT 7
`define PMW_WDC_CLR_BIT 6
`define PMW_WDC_RSTEN_BIT 5
`define PMW_WDC_IDLE_RUN_BIT 4
`define PMW_WDC_PS_MSB 2
`define PMW_WDC_PS_LSB 0
`define PMW_STAT_IDLE_BIT 0
`define PMW_STAT_PD_BIT 1
`define PMW_STAT_WDRST_BIT 2
`define PMW_STAT_PINRST_BIT 3
`define PMW_WDC_RESET 8'h00
`define PMW_RESET_VECTOR 16'h0000
`define PMW_RST_MIN_CLKS 24
`define PMW_CLKS_PER_MC 12
`endif

/* common/pmw_pkg.sv */
// Types shared by the power mode and watchdog modules.
package pmw_pkg;
    typedef enum logic [1:0] {
        PMW_RUN,
        PMW_IDLE,
        PMW_PDOWN
    } pmw_mode_t;

    typedef logic [2:0] pmw_psel_t;

    // Prescaler terminal mask: a factor of two to the power of code plus one.
    function automatic logic [7:0] pmw_ps_mask(input pmw_psel_t code);
        pmw_ps_mask = 8'((9'h002 << code) - 9'h001);
    endfunction : pmw_ps_mask
endpackage : pmw_pkg

/* common/pmw_wd_if.sv */
// Control and status bundle between the mode controller and the watchdog.
`timescale 1ns/1ps
interface pmw_wd_if;
    logic srst;
    logic run_en;
    logic clr;
    logic idle_run;
    logic rst_en;
    logic [2:0] psel;
    logic in_idle;
    logic halt;
    logic timeout;
    logic clr_done;

    modport ctl (output srst, run_en, clr, idle_run, rst_en, psel, in_idle, halt,
                 input timeout, clr_done);
    modport wd (input srst, run_en, clr, idle_run, rst_en, psel, in_idle, halt,
                output timeout, clr_done);
endinterface : pmw_wd_if

/* core/pmw_rst_filt.sv */
// Reset pin synchroniser and minimum-width filter.
`timescale 1ns/1ps
`include "pmw_cfg.svh"
module pmw_rst_filt (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic rst_pin,
    output logic rst_valid
);
    localparam int MIN_CLKS = `PMW_RST_MIN_CLKS;

    logic sync1_q;
    logic sync2_q;
    logic [4:0] cnt_q;

    // Two flops before anything looks at the pin.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= rst_pin;
            sync2_q <= sync1_q;
        end
    end

    // Counts consecutive high samples; a glitch shorter than the window is ignored.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 5'h00;
        end else if (!sync2_q) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != 5'(MIN_CLKS)) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    assign rst_valid = (cnt_q == 5'(MIN_CLKS)) && sync2_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_rst_short_ignored: assert property (
        $rose(rst_valid) |-> $past(sync2_q, MIN_CLKS))
        else $error("reset accepted before the pin stood high long enough");
endmodule : pmw_rst_filt

/* core/pmw_wdog.sv */
// Watchdog: machine-cycle divider, selectable prescaler and 14-bit timer.
`timescale 1ns/1ps
`include "pmw_cfg.svh"
module pmw_wdog
    import pmw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    pmw_wd_if.wd wd
);
    logic [3:0] mc_q;
    logic [7:0] pre_q;
    logic [13:0] tmr_q;
    logic mc_tick;
    logic active;
    logic pre_tick;

    assign mc_tick = (mc_q == 4'(`PMW_CLKS_PER_MC - 1)) && !wd.halt;
    // Stopped clocks in power-down freeze everything, so no time-out can end it.
    assign active = wd.run_en && !wd.halt && !(wd.in_idle && !wd.idle_run);
    assign pre_tick = active && mc_tick
                      && ((pre_q & pmw_ps_mask(wd.psel)) == pmw_ps_mask(wd.psel));

    // Machine-cycle divider; twelve oscillator periods per count.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mc_q <= 4'h0;
        end else if (wd.srst) begin
            mc_q <= 4'h0;
        end else if (!wd.halt) begin
            mc_q <= mc_tick ? 4'h0 : mc_q + 4'h1;
        end
    end

    // Prescaler and timer; a clear lands on the next machine-cycle boundary.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= 8'h00;
            tmr_q <= 14'h0000;
        end else if (wd.srst || (wd.clr && mc_tick)) begin
            pre_q <= 8'h00;
            tmr_q <= 14'h0000;
        end else if (active && mc_tick) begin
            pre_q <= pre_tick ? 8'h00 : pre_q + 8'h01;
            if (pre_tick) begin
                tmr_q <= tmr_q + 14'h0001;
            end
        end
    end

    assign wd.clr_done = wd.clr && mc_tick && !wd.srst;
    assign wd.timeout = pre_tick && (tmr_q == 14'h3fff) && !wd.clr && !wd.srst;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_frozen_in_pd: assert property (
        (wd.halt && !wd.srst) |=> $stable(tmr_q) && $stable(pre_q) && !wd.timeout)
        else $error("watchdog moved while powered down");
    a_idle_stop: assert property (
        (wd.in_idle && !wd.idle_run) |-> !pre_tick)
        else $error("watchdog counted in idle without idle-run");
    a_timer_step: assert property (
        (!wd.srst && !wd.clr && tmr_q != 14'h3fff && $changed(tmr_q) == 1'b0 && pre_tick)
        |=> tmr_q == $past(tmr_q) + 14'h0001)
        else $error("timer did not step on prescaler terminal count");
    a_clear_zero: assert property (
        wd.clr_done |=> tmr_q == 14'h0000 && pre_q == 8'h00)
        else $error("clear left timer or prescaler nonzero");
    a_run_gate: assert property (
        !wd.run_en |=> $stable(tmr_q) || tmr_q == 14'h0000)
        else $error("watchdog counted while disabled");
endmodule : pmw_wdog

/* tb/pmw_core_model.sv */
// Behavioural interrupt controller and reset pin source facing the block.
`timescale 1ns/1ps
////////////////////////////////////////
module pmw_core_model (
    input wire logic clk_sys,
    input wire logic wake_pulse,
    output logic irq_req,
    output logic ext_int_pin,
    output logic rst_pin,
    output logic ext_int_en,
    output logic global_interrupt_enable,
    output logic ext_int_level_mode
);
    // Everything starts quiet so the block sees no request out of reset.
    initial begin
        irq_req = 1'b0;
        ext_int_pin = 1'b0;
        rst_pin = 1'b0;
        {ext_int_en, global_interrupt_enable, ext_int_level_mode} = 3'h0;
    end
    // The controller retires its request once the core takes the wake-up vector.
    always @(posedge clk_sys) begin
        if (wake_pulse === 1'b1) begin
            irq_req <= 1'b0;
        end
    end
    // Callers sit on a rising edge, so every change lands just after it.
    task irq_set(input logic v);
        irq_req <= v;
    endtask : irq_set
    task ext_set(input logic v);
        ext_int_pin <= v;
    endtask : ext_set
    // The caller sets the high time; a valid reset needs 25 clocks or more.
    task rst_set(input logic v);
        rst_pin <= v;
    endtask : rst_set
    task cfg_set(input logic [2:0] c);
        {ext_int_en, global_interrupt_enable, ext_int_level_mode} <= c;
    endtask : cfg_set
endmodule : pmw_core_model

/* tb/tb.sv */
// Self-checking bench for the power mode and watchdog block.
`timescale 1ns/1ps
`include "pmw_cfg.svh"
////////////////////////////////////////
module tb;
    logic clk_sys, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic rst_pin, ext_int_pin, irq_req, ext_int_en, global_interrupt_enable;
    logic ext_int_level_mode, cpu_clk_en, periph_clk_en, port_hold, sfr_reset, wake_pulse;
    logic [15:0] reset_vector;
    int num_errors, samples_checked;

    pmw_top i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rst_pin(rst_pin),
        .ext_int_pin(ext_int_pin), .irq_req(irq_req), .ext_int_en(ext_int_en),
        .global_interrupt_enable(global_interrupt_enable),
        .ext_int_level_mode(ext_int_level_mode), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .port_hold(port_hold), .sfr_reset(sfr_reset),
        .wake_pulse(wake_pulse), .reset_vector(reset_vector));

    pmw_core_model i_core (.clk_sys(clk_sys), .wake_pulse(wake_pulse), .irq_req(irq_req),
        .ext_int_pin(ext_int_pin), .rst_pin(rst_pin), .ext_int_en(ext_int_en),
        .global_interrupt_enable(global_interrupt_enable),
        .ext_int_level_mode(ext_int_level_mode));

    // Free-running 50 MHz system clock.
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    // One classic cycle; the request holds until ack is sampled high at an edge.
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           input logic [3:0] sel, output logic [31:0] rdat);
        int n;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        chk(32'(wb_ack_o), 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb_xfer(1'b1, adr, dat, 4'hf, d);
    endtask : wr

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_xfer(1'b0, adr, 32'h0, 4'hf, d);
        chk(d, exp);
    endtask : rd

    // Counting pulses in a window also catches a wake pulse that lasts two cycles.
    task automatic wake_win(input int n, input logic [31:0] exp);
        int cnt;
        cnt = 0;
        repeat (n) begin
            @(posedge clk_sys);
            if (wake_pulse === 1'b1) cnt++;
        end
        chk(32'(cnt), exp);
    endtask : wake_win

    // Pin pulse of len clocks; the margin covers the synchroniser and filter.
    task automatic pin_pulse(input int len, input logic [31:0] exp);
        int seen;
        seen = 0;
        i_core.rst_set(1'b1);
        repeat (len) begin
            @(posedge clk_sys);
            if (sfr_reset === 1'b1) seen = 1;
        end
        i_core.rst_set(1'b0);
        repeat (8) begin
            @(posedge clk_sys);
            if (sfr_reset === 1'b1) seen = 1;
        end
        tick(4);
        chk(32'(seen), exp);
        chk(32'(sfr_reset), 32'h0);
    endtask : pin_pulse

    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, num_errors);
    endtask : done

    task automatic summarize();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // The whole sequence needs a few hundred clocks; this bound cuts a hang.
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        $display("bench timeout reached");
        summarize();
    end

    ////////////////////////////////////////
    // Main sequence. The full watchdog time-out needs over 390000 clocks, more than
    // the run budget allows, so the watchdog is covered through its control path.
    initial begin
        logic [31:0] d;
        logic [2:0] cfg;
        arst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        num_errors = 0;
        samples_checked = 0;
        tick(12);
        arst_n <= 1'b1;
        tick(3);
        chk(32'(sfr_reset), 32'h0);
        chk(32'(reset_vector), 32'(`PMW_RESET_VECTOR));
        chk(32'(cpu_clk_en), 32'h1);
        rd(`PMW_ADR_WDC, 32'(`PMW_WDC_RESET));
        rd(`PMW_ADR_PCTL, 32'h0);
        wr(8'h0c, 32'hff);
        rd(8'h0c, 32'h0);
        wb_xfer(1'b1, `PMW_ADR_PCTL, 32'h1, 4'he, d);
        tick(2);
        chk(32'(cpu_clk_en), 32'h1);
        done("reset and bus");
        wr(`PMW_ADR_PCTL, 32'h1);
        tick(2);
        chk({port_hold, periph_clk_en, cpu_clk_en}, 32'h6);
        rd(`PMW_ADR_PCTL, 32'h1);
        i_core.irq_set(1'b1);
        wake_win(8, 32'h1);
        chk({port_hold, cpu_clk_en}, 32'h1);
        rd(`PMW_ADR_PCTL, 32'h0);
        done("idle");
        wr(`PMW_ADR_PCTL, 32'h2);
        tick(2);
        chk({periph_clk_en, cpu_clk_en}, 32'h0);
        chk(32'(port_hold), 32'h1);
        i_core.irq_set(1'b1);
        wake_win(8, 32'h0);
        i_core.irq_set(1'b0);
        // Each pass leaves out one of the three wake conditions.
        for (int k = 0; k < 3; k++) begin
            cfg = 3'h7 ^ (3'h1 << k);
            i_core.cfg_set(cfg);
            i_core.ext_set(1'b1);
            wake_win(8, 32'h0);
            i_core.ext_set(1'b0);
            tick(4);
        end
        rd(`PMW_ADR_PCTL, 32'h2);
        i_core.cfg_set(3'h7);
        i_core.ext_set(1'b1);
        wake_win(8, 32'h1);
        i_core.ext_set(1'b0);
        chk({periph_clk_en, cpu_clk_en}, 32'h3);
        rd(`PMW_ADR_PCTL, 32'h0);
        done("power-down");
        wr(`PMW_ADR_PCTL, 32'h3);
        tick(2);
        chk(32'(periph_clk_en), 32'h0);
        rd(`PMW_ADR_PCTL, 32'h2);
        pin_pulse(23, 32'h0);
        rd(`PMW_ADR_PCTL, 32'h2);
        pin_pulse(28, 32'h1);
        rd(`PMW_ADR_PCTL, 32'h0);
        chk({periph_clk_en, cpu_clk_en}, 32'h3);
        rd(`PMW_ADR_STAT, 32'h8);
        wr(`PMW_ADR_STAT, 32'h8);
        rd(`PMW_ADR_STAT, 32'h0);
        done("pin reset");
        for (int c = 0; c < 8; c++) begin
            wr(`PMW_ADR_WDC, 32'h80 | 32'(c));
            rd(`PMW_ADR_WDC, 32'h80 | 32'(c));
        end
        wr(`PMW_ADR_WDC, 32'hb5);
        rd(`PMW_ADR_WDC, 32'hb5);
        wr(`PMW_ADR_WDC, 32'hf5);
        tick(14);
        rd(`PMW_ADR_WDC, 32'hb5);
        wr(`PMW_ADR_WDC, 32'ha4);
        rd(`PMW_ADR_WDC, 32'ha4);
        wr(`PMW_ADR_PCTL, 32'h1);
        pin_pulse(28, 32'h1);
        rd(`PMW_ADR_PCTL, 32'h0);
        rd(`PMW_ADR_WDC, 32'h0);
        chk(32'(reset_vector), 32'(`PMW_RESET_VECTOR));
        done("watchdog control");
        rd(`PMW_ADR_STAT, 32'h8);
        arst_n <= 1'b0;
        tick(2);
        arst_n <= 1'b1;
        tick(3);
        rd(`PMW_ADR_STAT, 32'h0);
        chk({sfr_reset, cpu_clk_en}, 32'h1);
        done("mid-run reset");
        summarize();
    end
endmodule : tb
